// *** verilog/pfcdf_top.sv ***
/*
  PFC gate generation, blanking, protection and enables, with an AXI4-Lite
  control/status port. Assumes comparator outputs arrive asynchronously and
  the analog thresholds, ramp, clamps and amplifier live outside.
*/
`timescale 1ns/100ps
// How it works
// - Grounded feedback node below threshold disables the whole controller.
// - Open feedback node rising above overvoltage also disables the controller.
// - Hard overvoltage ends the gate pulse at once and blocks new pulses.
// - Soft overvoltage reduction enabled while feedback sits in the window.
// - Boost current turns on when undervoltage deviation passes upper ratio.
// - Boost current turns off when deviation falls below lower ratio.
// - Boost current turns on at once when the stage becomes enabled.
// - Disabled stage pulls amplifier output low; enable releases it, clamps.
// - Divider switch open while disabled, closed while enabled.
// - On-time comparator trip ends the gate pulse.
// - No pulses below minimum control; on-time capped at internal maximum.
// - Current limit ignored during long blanking after gate turn-on.
// - After blanking, current limit turns the gate off immediately.
// - Short-circuit comparator sampled only after the short blanking window.
// - Four consecutive short-circuit pulses latch the stage off.
// - A clean pulse clears the short-circuit counter.
// - Short-circuit detection selects the long watchdog duration.
// - Watchdog expiry starts a pulse; each pulse restarts the watchdog.
// - Rising sense arms zero-cross; later rising trigger edge starts next cycle.
module pfcdf_top #(
  parameter logic [15:0] WD_LONG_CYC = pfcdf_pkg::WD_LONG_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Comparator outputs, asynchronous
  input wire logic fb_low_short,
  input wire logic hard_ovp,
  input wire logic soft_ovp_win,
  input wire logic uv_above_high,
  input wire logic uv_below_low,
  input wire logic ontime_trip,
  input wire logic ctrl_below_min,
  input wire logic cur_limit,
  input wire logic short_circuit,
  input wire logic zcd_arm,
  input wire logic zcd_trig,
  // Gate and analog enables
  output logic pfc_gate_out,
  output logic long_blank_window,
  output logic short_blank_window,
  output logic divider_disconnect_switch,
  output logic pulldown_en,
  output logic lower_clamp_en,
  output logic control_boost_current,
  output logic soft_ovp_en,
  output logic long_watchdog_sel,
  output logic controller_disable,
  output logic latched_off,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [pfcdf_pkg::NCMP-1:0] sync1_ff, sync2_ff;
  logic arm_q_ff, trig_q_ff, stage_q_ff;
  pfcdf_pkg::pfcdf_state_t state_ff, nxt_state;
  logic [15:0] on_cnt_ff, wd_cnt_ff;
  logic [2:0] strike_ff;
  logic sc_seen_ff, gate_ff, leb1_ff, leb2_ff, fbsw_ff, pd_ff, clamp_ff;
  logic boost_ff, soft_ff, wdl_ff, dis_ff, latch_ff, en_ff;
  logic aw_got_ff, w_got_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic wstrb0_ff;
  logic [1:0] bresp_ff, rresp_ff;

  // Synchronised comparator levels
  wire short_s, ovp_s, soft_s, uvh_s, uvl_s, ton_s, min_s, cl_s, sc_s, arm_s, trig_s;
  assign {short_s, ovp_s, soft_s, uvh_s, uvl_s, ton_s, min_s, cl_s, sc_s, arm_s,
          trig_s} = sync2_ff;

  // Stage control
  wire stage_on = en_ff & ~latch_ff;
  wire en_rise = stage_on & ~stage_q_ff;
  wire fault_hold = short_s | ovp_s;
  wire can_run = stage_on & ~fault_hold & ~min_s;
  wire arm_edge = arm_s & ~arm_q_ff;
  wire trig_edge = trig_s & ~trig_q_ff;
  wire [15:0] wd_limit = wdl_ff ? WD_LONG_CYC : pfcdf_pkg::WD_BASE_CYC;
  wire wd_expired = wd_cnt_ff >= wd_limit - pfcdf_pkg::CNT_ONE;
  wire in_on = state_ff == pfcdf_pkg::ST_ON;
  wire sc_hit = in_on & ~leb2_ff & sc_s;
  wire cl_hit = in_on & ~leb1_ff & cl_s;
  wire ton_max = on_cnt_ff >= pfcdf_pkg::TON_MAX_CYC - pfcdf_pkg::CNT_ONE;
  wire pulse_stop = ~can_run | ton_s | ton_max | cl_hit | sc_hit;
  wire armed_trig = (state_ff == pfcdf_pkg::ST_ARMED) & trig_edge;
  wire start_ok = can_run & (wd_expired | armed_trig);
  wire last_strike = sc_seen_ff & (strike_ff == pfcdf_pkg::STRIKE_MAX - pfcdf_pkg::STRIKE_ONE);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pfcdf_pkg::ST_WAIT: begin
        if (start_ok) begin
          nxt_state = pfcdf_pkg::ST_ON;
        end else if (arm_edge) begin
          nxt_state = pfcdf_pkg::ST_ARMED;
        end
      end
      pfcdf_pkg::ST_ARMED: begin
        if (start_ok) begin
          nxt_state = pfcdf_pkg::ST_ON;
        end
      end
      pfcdf_pkg::ST_ON: begin
        if (pulse_stop) begin
          nxt_state = pfcdf_pkg::ST_END;
        end
      end
      pfcdf_pkg::ST_END: nxt_state = pfcdf_pkg::ST_WAIT;
    endcase
  end

  wire nxt_gate = nxt_state == pfcdf_pkg::ST_ON;
  wire pulse_begin = nxt_gate & ~in_on;
  wire [15:0] nxt_on_cnt = in_on ? on_cnt_ff + pfcdf_pkg::CNT_ONE : pfcdf_pkg::CNT_ZERO;
  // Restart at pulse start, so the period runs start to start
  // Frozen at zero while a hard fault holds the stage off
  wire [15:0] nxt_wd_cnt = (pulse_begin | fault_hold) ? pfcdf_pkg::CNT_ZERO :
                           (wd_expired ? wd_cnt_ff : wd_cnt_ff + pfcdf_pkg::CNT_ONE);
  wire at_end = state_ff == pfcdf_pkg::ST_END;
  wire [2:0] nxt_strike = ~at_end ? strike_ff :
                          sc_seen_ff ? strike_ff + pfcdf_pkg::STRIKE_ONE :
                          pfcdf_pkg::STRIKE_RST;
  // Kept through the END cycle, where the strike count reads it
  wire nxt_sc_seen = in_on & (sc_seen_ff | sc_hit);
  wire nxt_boost = ~stage_on ? 1'b0 : (en_rise | uvh_s) ? 1'b1 :
                   uvl_s ? 1'b0 : boost_ff;
  wire nxt_wdl = sc_hit ? 1'b1 : (at_end & ~sc_seen_ff) ? 1'b0 : wdl_ff;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= pfcdf_pkg::CMP_RST;
      sync2_ff <= pfcdf_pkg::CMP_RST;
    end else begin
      sync1_ff <= {fb_low_short, hard_ovp, soft_ovp_win, uv_above_high, uv_below_low,
                   ontime_trip, ctrl_below_min, cur_limit, short_circuit, zcd_arm, zcd_trig};
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= pfcdf_pkg::ST_WAIT;
      on_cnt_ff <= pfcdf_pkg::CNT_ZERO;
      wd_cnt_ff <= pfcdf_pkg::CNT_ZERO;
      strike_ff <= pfcdf_pkg::STRIKE_RST;
      sc_seen_ff <= 1'b0;
      arm_q_ff <= 1'b0;
      trig_q_ff <= 1'b0;
      stage_q_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      on_cnt_ff <= nxt_on_cnt;
      wd_cnt_ff <= nxt_wd_cnt;
      strike_ff <= nxt_strike;
      sc_seen_ff <= nxt_sc_seen;
      arm_q_ff <= arm_s;
      trig_q_ff <= trig_s;
      stage_q_ff <= stage_on;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gate_ff <= 1'b0;
      leb1_ff <= 1'b0;
      leb2_ff <= 1'b0;
      fbsw_ff <= 1'b0;
      pd_ff <= 1'b1;
      clamp_ff <= 1'b0;
      boost_ff <= 1'b0;
      soft_ff <= 1'b0;
      wdl_ff <= 1'b0;
      dis_ff <= 1'b0;
      latch_ff <= 1'b0;
    end else begin
      gate_ff <= nxt_gate;
      leb1_ff <= nxt_gate & (nxt_on_cnt < pfcdf_pkg::LEB1_CYC);
      leb2_ff <= nxt_gate & (nxt_on_cnt < pfcdf_pkg::LEB2_CYC);
      fbsw_ff <= stage_on;
      pd_ff <= ~stage_on;
      clamp_ff <= stage_on;
      boost_ff <= nxt_boost;
      soft_ff <= soft_s;
      wdl_ff <= nxt_wdl;
      dis_ff <= fault_hold;
      latch_ff <= latch_ff | (at_end & last_strike);
    end
  end

  // AXI4-Lite: address and data taken in either order, one write at a time
  wire aw_hs = s_axi_awvalid & awready_ff;
  wire w_hs = s_axi_wvalid & wready_ff;
  wire have_aw = aw_got_ff | aw_hs;
  wire have_w = w_got_ff | w_hs;
  wire do_wr = have_aw & have_w & ~bvalid_ff;
  wire [3:0] wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
  wire wr_lane0 = w_got_ff ? wstrb0_ff : s_axi_wstrb[0];
  wire wr_ctrl = do_wr & (wr_addr == pfcdf_pkg::ADDR_CTRL);
  wire wr_ok = (wr_addr == pfcdf_pkg::ADDR_CTRL) | (wr_addr == pfcdf_pkg::ADDR_STAT);
  wire nxt_aw_got = have_aw & ~do_wr;
  wire nxt_w_got = have_w & ~do_wr;
  wire nxt_bvalid = do_wr | (bvalid_ff & ~s_axi_bready);
  wire ar_hs = s_axi_arvalid & arready_ff;
  wire nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready);
  // Status shows live block state; strike count is the pending tally
  wire [31:0] stat_word = {21'h000000, strike_ff, 2'h0, wdl_ff, soft_ff, boost_ff, gate_ff,
                           dis_ff, latch_ff};
  wire [31:0] ctrl_word = {31'h00000000, en_ff};
  wire rd_ctrl = s_axi_araddr == pfcdf_pkg::ADDR_CTRL;
  wire rd_stat = s_axi_araddr == pfcdf_pkg::ADDR_STAT;
  wire [31:0] rd_word = rd_ctrl ? ctrl_word : rd_stat ? stat_word : pfcdf_pkg::WORD_ZERO;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= pfcdf_pkg::WORD_ZERO;
      wstrb0_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= pfcdf_pkg::RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= pfcdf_pkg::WORD_ZERO;
      rresp_ff <= pfcdf_pkg::RESP_OKAY;
      en_ff <= 1'b0;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff <= ~nxt_w_got & ~nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (do_wr) begin
        bresp_ff <= wr_ok ? pfcdf_pkg::RESP_OKAY : pfcdf_pkg::RESP_SLVERR;
      end
      if (wr_ctrl & wr_lane0) begin
        en_ff <= wr_data[pfcdf_pkg::CTRL_EN_BIT];
      end
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= rd_word;
        rresp_ff <= (rd_ctrl | rd_stat) ? pfcdf_pkg::RESP_OKAY : pfcdf_pkg::RESP_SLVERR;
      end
    end
  end

  assign pfc_gate_out = gate_ff;
  assign long_blank_window = leb1_ff;
  assign short_blank_window = leb2_ff;
  assign divider_disconnect_switch = fbsw_ff;
  assign pulldown_en = pd_ff;
  assign lower_clamp_en = clamp_ff;
  assign control_boost_current = boost_ff;
  assign soft_ovp_en = soft_ff;
  assign long_watchdog_sel = wdl_ff;
  assign controller_disable = dis_ff;
  assign latched_off = latch_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_start;
    $rose(gate_ff);
  endsequence
  sequence s_clean_end;
    at_end && !sc_seen_ff;
  endsequence
  property p_short_dis;
    short_s |=> dis_ff;
  endproperty
  a_short_dis: assert property (p_short_dis) else $error("short pin not disabling");
  property p_ovp_dis;
    ovp_s && !short_s |=> dis_ff;
  endproperty
  a_ovp_dis: assert property (p_ovp_dis) else $error("open pin not disabling");
  property p_ovp_gate;
    ovp_s |=> !gate_ff;
  endproperty
  a_ovp_gate: assert property (p_ovp_gate) else $error("gate on under hard ovp");
  property p_soft;
    soft_s |=> soft_ff;
  endproperty
  a_soft: assert property (p_soft) else $error("soft ovp not enabled");
  property p_boost_rise;
    $rose(stage_on) |=> boost_ff;
  endproperty
  a_boost_rise: assert property (p_boost_rise) else $error("boost late on enable");
  property p_disabled;
    !stage_on |=> pd_ff && !fbsw_ff && !clamp_ff;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled outputs wrong");
  property p_leb1;
    s_start |-> leb1_ff ##1 (leb1_ff || !gate_ff)[*6] ##1 (!leb1_ff || $rose(gate_ff));
  endproperty
  a_leb1: assert property (p_leb1) else $error("long blanking length wrong");
  property p_leb2;
    leb2_ff[*4] |=> !leb2_ff;
  endproperty
  a_leb2: assert property (p_leb2) else $error("short blanking too long");
  property p_cl;
    cl_hit |=> !gate_ff;
  endproperty
  a_cl: assert property (p_cl) else $error("current limit missed");
  property p_maxon;
    s_start |-> ##[1:300] !gate_ff;
  endproperty
  a_maxon: assert property (p_maxon) else $error("on-time above maximum");
  property p_clean;
    s_clean_end |=> strike_ff == pfcdf_pkg::STRIKE_RST;
  endproperty
  a_clean: assert property (p_clean) else $error("strike count not cleared");
  property p_latch;
    latch_ff |=> latch_ff && !gate_ff;
  endproperty
  a_latch: assert property (p_latch) else $error("latch released or gate on");
  property p_wdl;
    sc_hit |=> wdl_ff;
  endproperty
  a_wdl: assert property (p_wdl) else $error("long watchdog not selected");
endmodule

// *** verilog/pfcdf_pkg.sv ***
/*
  Constants, register map and state type for the PFC drive and fault logic.
  Assumes a 50 ns system clock; all counts are derived from it.
*/
package pfcdf_pkg;
  localparam int CLK_NS = 50;
  // Blanking and on-time, ns
  localparam int LEB1_NS = 325;
  localparam int LEB2_NS = 175;
  localparam int TON_MAX_NS = 15000;
  // Watchdog, us
  localparam int WD_BASE_US = 200;
  localparam int WD_LONG_US = 1000;
  localparam int CNT_W = 16;
  // Least times round up, longest round down
  localparam logic [CNT_W-1:0] LEB1_CYC = CNT_W'((LEB1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] LEB2_CYC = CNT_W'((LEB2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] TON_MAX_CYC = CNT_W'(TON_MAX_NS / CLK_NS);
  localparam logic [CNT_W-1:0] WD_BASE_CYC = CNT_W'(WD_BASE_US * 1000 / CLK_NS);
  localparam logic [CNT_W-1:0] WD_LONG_CYC = CNT_W'(WD_LONG_US * 1000 / CLK_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  // Short-circuit strikes
  localparam logic [2:0] STRIKE_MAX = 3'h4;
  localparam logic [2:0] STRIKE_ONE = 3'h1;
  localparam logic [2:0] STRIKE_RST = 3'h0;
  // Register map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h4;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NCMP = 11;
  localparam logic [NCMP-1:0] CMP_RST = 11'h000;
  typedef enum logic [1:0] {
    ST_WAIT = 2'h0,
    ST_ARMED = 2'h1,
    ST_ON = 2'h3,
    ST_END = 2'h2
  } pfcdf_state_t;
endpackage

// *** sim/pfcdf_partner.sv ***
/*
  Far side of the PFC block: on-time ramp, sense comparators, ZCD winding.
  Assumes the bench changes the fault modes only while the gate is low.
*/
`timescale 1ns/100ps
module pfcdf_partner #(
  parameter int TRIP_CYC = 20
) (
  // Clock
  input wire logic mclk,
  // Gate and bench controls
  input wire logic pfc_gate_out,
  input wire logic zcd_en,
  input wire logic cl_mode,
  input wire logic sc_mode,
  // Comparator levels
  output logic ontime_trip,
  output logic cur_limit,
  output logic short_circuit,
  output logic zcd_arm,
  output logic zcd_trig
);
  int on_cnt = 0;
  int off_cnt = 0;
  always @(posedge mclk) begin
    on_cnt <= pfc_gate_out ? on_cnt + 1 : 0;
    off_cnt <= pfc_gate_out ? 0 : off_cnt + 1;
  end
  // Ramp restarts every pulse, so the trip tracks gate width
  assign ontime_trip = on_cnt >= TRIP_CYC;
  // Sense current flows only while the switch conducts
  assign cur_limit = cl_mode & pfc_gate_out;
  assign short_circuit = sc_mode & pfc_gate_out;
  // Ringing after turn-off: arm first, then trigger; no winding, no edges
  assign zcd_arm = zcd_en & off_cnt > 1 & off_cnt < 8;
  assign zcd_trig = zcd_en & off_cnt > 12;
endmodule

// *** sim/pfcdf_top_bench.sv ***
/*
  Self-checking bench for the PFC gate and fault block.
  Assumes the partner model answers the gate with comparator levels.
*/
`timescale 1ns/100ps
module pfcdf_top_bench;
  localparam int TRIP = 20;
  localparam int WDL = 40;
  logic mclk = 1'h0;
  logic rstn = 1'h0;
  logic fb_low_short = 1'h0, hard_ovp = 1'h0, soft_ovp_win = 1'h0, uv_above_high = 1'h0;
  logic uv_below_low = 1'h0, ctrl_below_min = 1'h0, zcd_en = 1'h0;
  logic cl_mode = 1'h0, sc_mode = 1'h0;
  logic ontime_trip, cur_limit, short_circuit, zcd_arm, zcd_trig;
  logic gate, leb1, leb2, sw, pd, clamp, boost, sovp, lwd, cdis, latch;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int fails = 0;
  int comparisons = 0;
  always #25 mclk = ~mclk;
  pfcdf_top #(.WD_LONG_CYC(16'h0028)) u_dut (.mclk(mclk), .rstn(rstn),
    .fb_low_short(fb_low_short), .hard_ovp(hard_ovp), .soft_ovp_win(soft_ovp_win),
    .uv_above_high(uv_above_high), .uv_below_low(uv_below_low), .ontime_trip(ontime_trip),
    .ctrl_below_min(ctrl_below_min), .cur_limit(cur_limit), .short_circuit(short_circuit),
    .zcd_arm(zcd_arm), .zcd_trig(zcd_trig), .pfc_gate_out(gate), .long_blank_window(leb1),
    .short_blank_window(leb2), .divider_disconnect_switch(sw), .pulldown_en(pd),
    .lower_clamp_en(clamp), .control_boost_current(boost), .soft_ovp_en(sovp),
    .long_watchdog_sel(lwd), .controller_disable(cdis), .latched_off(latch),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  pfcdf_partner #(.TRIP_CYC(TRIP)) u_far (.mclk(mclk), .pfc_gate_out(gate), .zcd_en(zcd_en),
    .cl_mode(cl_mode), .sc_mode(sc_mode), .ontime_trip(ontime_trip), .cur_limit(cur_limit),
    .short_circuit(short_circuit), .zcd_arm(zcd_arm), .zcd_trig(zcd_trig));
  task automatic finish_test();
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic bail();
    fails++;
    finish_test();
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (exp !== got) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic rng(string name, int lo, int hi, int got);
    comparisons++;
    if (got < lo || got > hi) begin
      fails++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic do_reset();
    rstn <= 1'h0;
    tick(5);
    rstn <= 1'h1;
    tick(2);
  endtask
  task automatic axi_wr(logic [3:0] a, logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 20 && bvalid !== 1'h1; n++) begin
      @(posedge mclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end
    if (n == 20) bail();
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic axi_rd(logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 20 && rvalid !== 1'h1; n++) begin
      @(posedge mclk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end
    if (n == 20) bail();
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  task automatic rise(output int wt);
    for (wt = 0; gate !== 1'h1; wt++) begin
      @(posedge mclk);
      if (wt > 5000) bail();
    end
  endtask
  // Width and blanking coverage of the next gate pulse
  task automatic pulse(output int wt, output int w, output int n1, output int n2);
    rise(wt);
    w = 0;
    n1 = 0;
    n2 = 0;
    while (gate === 1'h1) begin
      w++;
      n1 += int'(leb1);
      n2 += int'(leb2);
      @(posedge mclk);
      if (w > 400) bail();
    end
  endtask
  task automatic hi_cnt(int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge mclk);
      c += int'(gate === 1'h1);
    end
  endtask
  task automatic t_reset();
    chk("pulldown", 1'h1, pd);
    chk("switch", 1'h0, sw);
    chk("gate", 1'h0, gate);
  endtask
  task automatic t_enable();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(pfcdf_pkg::ADDR_CTRL, 32'h0000_0001, r);
    chk("bresp", pfcdf_pkg::RESP_OKAY, r);
    tick(2);
    chk("switch", 1'h1, sw);
    chk("pulldown", 1'h0, pd);
    chk("clamp", 1'h1, clamp);
    chk("boost", 1'h1, boost);
    axi_rd(4'hC, d, r);
    chk("rresp", pfcdf_pkg::RESP_SLVERR, r);
    chk("rdata", 32'h0, d);
  endtask
  task automatic t_zcd();
    int wt, w, n1, n2;
    zcd_en <= 1'h1;
    pulse(wt, w, n1, n2);
    pulse(wt, w, n1, n2);
    rng("zcd gap", 12, 22, wt);
    rng("on width", TRIP + 1, TRIP + 5, w);
    chk("long blank", 32'd7, n1);
    chk("short blank", 32'd4, n2);
    cl_mode <= 1'h1;
    pulse(wt, w, n1, n2);
    rng("limit width", 8, 9, w);
    cl_mode <= 1'h0;
  endtask
  task automatic t_levels();
    uv_below_low <= 1'h1;
    tick(5);
    chk("boost off", 1'h0, boost);
    uv_below_low <= 1'h0;
    uv_above_high <= 1'h1;
    tick(5);
    chk("boost on", 1'h1, boost);
    uv_above_high <= 1'h0;
    soft_ovp_win <= 1'h1;
    tick(5);
    chk("boost held", 1'h1, boost);
    chk("soft ovp", 1'h1, sovp);
    soft_ovp_win <= 1'h0;
    tick(5);
    chk("soft ovp off", 1'h0, sovp);
  endtask
  task automatic t_faults();
    int wt, c;
    rise(wt);
    hard_ovp <= 1'h1;
    tick(4);
    chk("ovp gate", 1'h0, gate);
    chk("ovp disable", 1'h1, cdis);
    hi_cnt(60, c);
    chk("ovp pulses", 32'd0, c);
    hard_ovp <= 1'h0;
    fb_low_short <= 1'h1;
    tick(4);
    chk("short pin", 1'h1, cdis);
    fb_low_short <= 1'h0;
    ctrl_below_min <= 1'h1;
    tick(4);
    chk("short pin off", 1'h0, cdis);
    // Long enough for the watchdog to expire while held
    hi_cnt(4100, c);
    chk("min pulses", 32'd0, c);
    ctrl_below_min <= 1'h0;
  endtask
  task automatic t_wdog();
    int wt, w, p, n1, n2;
    zcd_en <= 1'h0;
    pulse(wt, p, n1, n2);
    pulse(wt, w, n1, n2);
    rng("base wdog", pfcdf_pkg::WD_BASE_CYC - 20, pfcdf_pkg::WD_BASE_CYC + 20, wt + p);
    sc_mode <= 1'h1;
    pulse(wt, p, n1, n2);
    sc_mode <= 1'h0;
    rng("sc width", 5, 6, p);
    chk("long wdog", 1'h1, lwd);
    pulse(wt, w, n1, n2);
    rng("long gap", WDL - 5, WDL + 5, wt + p);
  endtask
  task automatic t_strike();
    int wt, w, n1, n2, c;
    logic [31:0] d;
    logic [1:0] r;
    zcd_en <= 1'h1;
    sc_mode <= 1'h1;
    repeat (3) pulse(wt, w, n1, n2);
    sc_mode <= 1'h0;
    axi_rd(pfcdf_pkg::ADDR_STAT, d, r);
    chk("strikes", 32'h3, d[10:8]);
    pulse(wt, w, n1, n2);
    axi_rd(pfcdf_pkg::ADDR_STAT, d, r);
    chk("strikes cleared", 32'h0, d[10:8]);
    sc_mode <= 1'h1;
    repeat (4) pulse(wt, w, n1, n2);
    sc_mode <= 1'h0;
    tick(3);
    chk("latched", 1'h1, latch);
    hi_cnt(100, c);
    chk("latched pulses", 32'd0, c);
    axi_rd(pfcdf_pkg::ADDR_STAT, d, r);
    chk("latch status", 1'h1, d[0]);
    do_reset();
    chk("latch reset", 1'h0, latch);
  endtask
  initial begin
    do_reset();
    t_reset();
    t_enable();
    t_zcd();
    t_levels();
    t_faults();
    t_wdog();
    t_strike();
    finish_test();
  end
endmodule
